// [verilog/ist_timing_map.svh]
// State cost and cycle count constants for the instruction state timer.
// Assumes inclusion by bare name from the timer module; the package does not include it.
`ifndef IST_TIMING_MAP_SVH
`define IST_TIMING_MAP_SVH

// Per-cycle state costs, on-chip memory and internal cycles
`define IST_S_FETCH_MEM      4'h2
`define IST_S_BRADDR_MEM     4'h2
`define IST_S_STACK_MEM      4'h2
`define IST_S_BYTE_MEM       4'h2
`define IST_S_WORD_MEM       4'h2
`define IST_S_INTERNAL       4'h1
// Peripheral access: byte two or three states by module, word four
`define IST_S_BYTE_PERI_FAST 4'h2
`define IST_S_BYTE_PERI_SLOW 4'h3
`define IST_S_WORD_PERI      4'h4

// Cycle counts for the decoded instruction classes
`define IST_N_NONE           4'h0
`define IST_N_ONE            4'h1
`define IST_N_TWO            4'h2

`endif

// [verilog/ist_pkg.sv]
// Types for the instruction state timer.
// Assumes the constant header is on the include path.
package ist_pkg;
   typedef enum logic [3:0] {
      IST_OP_ADD_REG     = 4'h0, // Byte/word add, register or immediate
      IST_OP_ADD_SMALL   = 4'h1, // add_small_constant_word #1 / #2
      IST_OP_ADD_EXTEND  = 4'h2, // add_with_extend
      IST_OP_SHORT_BR    = 4'h3, // conditional_short_branch
      IST_OP_BIT_LOGIC_M = 4'h4, // Bit logic on memory operand
      IST_OP_BIT_SETCL_M = 4'h5, // bit_set_op / bit_clear_op on memory
      IST_OP_CALL_IND    = 4'h6, // subroutine_call, memory indirect
      IST_OP_BIT_REG     = 4'h7  // Bit operation on register
   } ist_op_e;

   typedef enum logic [2:0] {
      IST_IDLE = 3'b001,
      IST_LOAD = 3'b010,
      IST_RUN  = 3'b100
   } ist_state_e;

   typedef struct packed {
      logic [3:0] fetch;
      logic [3:0] brAddr;
      logic [3:0] stack;
      logic [3:0] byteAcc;
      logic [3:0] wordAcc;
      logic [3:0] internal;
   } ist_counts_s;
endpackage : ist_pkg

// [verilog/ist_state_timer.sv]
// Instruction state timer: decodes an instruction class into per-type
// cycle counts, prices them by access location and counts the states.
// Assumes opStart is a one-cycle pulse from the same clock domain.
// Functional notes
// [RULE1] Total states are the sum over six cycle types of count times cost.
// [RULE2] Each type's cost is picked by memory versus peripheral location; here only byte and word costs change with location.
// [RULE3] A fetch and a byte access to on-chip memory each cost 2 states.
// [RULE4] A peripheral byte access costs 2 or 3 states by module addressed.
// [RULE5] Indirect call: two fetches, one address read, one stack, 2 each.
// [RULE6] Register and immediate byte and word add and add_with_extend take a single fetch.
// [RULE7] Adding 1 or 2 to a word register takes a single fetch only.
// [RULE8] Short branches take two fetches; bit ops on memory add byte reads.
`timescale 1ns/10ps
`include "ist_timing_map.svh"

module ist_state_timer (
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   input  wire logic               opStart,
   input  wire ist_pkg::ist_op_e   opClass,
   input  wire logic               fetchPeri,
   input  wire logic               brAddrPeri,
   input  wire logic               stackPeri,
   input  wire logic               dataPeri,
   input  wire logic               slowPeri,
   output logic                    busy,
   output logic                    opDone,
   output logic [7:0]              totalStates,
   output logic [7:0]              statesLeft
);
   ist_pkg::ist_state_e  state_q;
   ist_pkg::ist_counts_s cnt;
   logic [7:0]           total_d;
   logic [7:0]           total_q;
   logic [7:0]           left_q;
   logic                 done_q;
   logic [3:0]           sFetch;
   logic [3:0]           sBr;
   logic [3:0]           sStack;
   logic [3:0]           sByte;
   logic [3:0]           sWord;
   logic [3:0]           sInt;
   logic [7:0]           tFetch;
   logic [7:0]           tBr;
   logic [7:0]           tStack;
   logic [7:0]           tByte;
   logic [7:0]           tWord;
   logic [7:0]           tInt;

   // Cost of one cycle by location; peripheral fetch has no defined price,
   // so it is priced like memory rather than left open
   function automatic logic [3:0] pick(input logic peri,
                                       input logic [3:0] memCost,
                                       input logic [3:0] periCost);
      pick = peri ? periCost : memCost;
   endfunction : pick

   function automatic logic [7:0] term(input logic [3:0] n,
                                       input logic [3:0] s);
      term = {4'h0, n} * {4'h0, s};
   endfunction : term

   always_comb begin
      sFetch = pick(fetchPeri, `IST_S_FETCH_MEM, `IST_S_FETCH_MEM); // RULE3
      sBr    = pick(brAddrPeri, `IST_S_BRADDR_MEM, `IST_S_BRADDR_MEM);
      sStack = pick(stackPeri, `IST_S_STACK_MEM, `IST_S_STACK_MEM);
      sByte  = pick(dataPeri, `IST_S_BYTE_MEM, // RULE2
                    slowPeri ? `IST_S_BYTE_PERI_SLOW
                             : `IST_S_BYTE_PERI_FAST); // RULE4
      sWord  = pick(dataPeri, `IST_S_WORD_MEM, `IST_S_WORD_PERI);
      // Internal cycles touch no bus, so their cost has no location
      sInt   = `IST_S_INTERNAL;
   end

   always_comb begin
      // Every class lists all six cycle counts, so a missing column shows
      cnt = '0;
      unique case (opClass)
         ist_pkg::IST_OP_ADD_REG: begin
            cnt.fetch    = `IST_N_ONE; // RULE6
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_NONE;
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         ist_pkg::IST_OP_ADD_EXTEND: begin
            cnt.fetch    = `IST_N_ONE; // RULE6
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_NONE;
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         ist_pkg::IST_OP_ADD_SMALL: begin
            cnt.fetch    = `IST_N_ONE; // RULE7
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_NONE;
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         ist_pkg::IST_OP_SHORT_BR: begin
            cnt.fetch    = `IST_N_TWO; // RULE8
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_NONE;
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         ist_pkg::IST_OP_BIT_LOGIC_M: begin
            cnt.fetch    = `IST_N_TWO; // RULE8
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_ONE; // RULE8
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         ist_pkg::IST_OP_BIT_SETCL_M: begin
            cnt.fetch    = `IST_N_TWO; // RULE8
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_TWO; // RULE8
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         ist_pkg::IST_OP_CALL_IND: begin
            cnt.fetch    = `IST_N_TWO; // RULE5
            cnt.brAddr   = `IST_N_ONE; // RULE5
            cnt.stack    = `IST_N_ONE; // RULE5
            cnt.byteAcc  = `IST_N_NONE;
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         ist_pkg::IST_OP_BIT_REG: begin
            cnt.fetch    = `IST_N_ONE;
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_NONE;
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
         default: begin
            cnt.fetch    = `IST_N_ONE;
            cnt.brAddr   = `IST_N_NONE;
            cnt.stack    = `IST_N_NONE;
            cnt.byteAcc  = `IST_N_NONE;
            cnt.wordAcc  = `IST_N_NONE;
            cnt.internal = `IST_N_NONE;
         end
      endcase
   end

   // One product per cycle type; the eight-bit sum would wrap above 255
   // states, far beyond any class decoded here
   always_comb begin
      tFetch = term(cnt.fetch, sFetch);
      tBr    = term(cnt.brAddr, sBr);
      tStack = term(cnt.stack, sStack);
      tByte  = term(cnt.byteAcc, sByte);
      tWord  = term(cnt.wordAcc, sWord);
      tInt   = term(cnt.internal, sInt);
   end

   always_comb begin
      total_d = tFetch + tBr + tStack + tByte + tWord + tInt; // RULE1
   end

   // Starts while busy are ignored: the core issues one at a time
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ist_pkg::IST_IDLE;
      end else begin
         unique case (state_q)
            ist_pkg::IST_IDLE: begin
               if (opStart) begin
                  state_q <= ist_pkg::IST_LOAD;
               end
            end
            ist_pkg::IST_LOAD: begin
               state_q <= ist_pkg::IST_RUN;
            end
            ist_pkg::IST_RUN: begin
               if (left_q == 8'h01) begin
                  state_q <= ist_pkg::IST_IDLE;
               end
            end
            default: begin
               state_q <= ist_pkg::IST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         total_q <= 8'h00;
      end else if (state_q == ist_pkg::IST_IDLE && opStart) begin
         total_q <= total_d; // RULE1
      end
   end

   // The instruction occupies exactly total_q clocks in RUN
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         left_q <= 8'h00;
      end else if (state_q == ist_pkg::IST_LOAD) begin
         left_q <= total_q; // RULE1
      end else if (state_q == ist_pkg::IST_RUN && left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == ist_pkg::IST_RUN) && (left_q == 8'h01);
      end
   end

   assign busy        = (state_q != ist_pkg::IST_IDLE);
   assign opDone      = done_q;
   assign totalStates = total_q;
   assign statesLeft  = left_q;
endmodule : ist_state_timer

// [tb/ist_state_timer_monitor.sv]
// Checker for the instruction state timer, bound to its ports.
// Assumes inputs change away from the rising clock edge.
`timescale 1ns/10ps
module ist_state_timer_monitor (
   input wire logic             sys_clk,
   input wire logic             nrst,
   input wire logic             opStart,
   input wire ist_pkg::ist_op_e opClass,
   input wire logic             dataPeri,
   input wire logic             slowPeri,
   input wire logic             busy,
   input wire logic             opDone,
   input wire logic [7:0]       totalStates,
   input wire logic [7:0]       statesLeft
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire tk = opStart && !busy;
   start_busy_a: assert property (
      tk |=> busy) else $error("busy did not rise after a start");
   add_time_a: assert property (
      tk && opClass == ist_pkg::IST_OP_ADD_REG
      |=> busy [*3] ##1 (opDone && !busy)) else $error("add timing off");
   small_add_a: assert property (
      tk && opClass == ist_pkg::IST_OP_ADD_SMALL
      |=> totalStates == 8'h02) else $error("small add total off");
   short_br_a: assert property (
      tk && opClass == ist_pkg::IST_OP_SHORT_BR
      |=> totalStates == 8'h04) else $error("branch total off");
   call_cost_a: assert property (
      tk && opClass == ist_pkg::IST_OP_CALL_IND
      |=> totalStates == 8'h08) else $error("call total off");
   slow_peri_a: assert property (
      tk && opClass == ist_pkg::IST_OP_BIT_LOGIC_M && dataPeri && slowPeri
      |=> totalStates == 8'h07) else $error("slow peri");
   mem_byte_a: assert property (
      tk && opClass == ist_pkg::IST_OP_BIT_SETCL_M && !dataPeri
      |=> totalStates == 8'h08) else $error("memory byte off");
   done_pulse_a: assert property (
      opDone |=> !opDone) else $error("done longer than one cycle");
   fast_peri_a: assert property (
      tk && opClass == ist_pkg::IST_OP_BIT_SETCL_M && dataPeri && !slowPeri
      |=> totalStates == 8'h08) else $error("fast peri");
   left_load_a: assert property (
      tk |=> ##1 statesLeft == totalStates)
      else $error("count not loaded");
   count_drained_a: assert property (
      opDone |-> statesLeft == 8'h00 && !busy)
      else $error("count not drained");
endmodule : ist_state_timer_monitor

bind ist_state_timer ist_state_timer_monitor mon (.sys_clk(sys_clk),
   .nrst(nrst), .opStart(opStart), .opClass(opClass), .dataPeri(dataPeri),
   .slowPeri(slowPeri), .busy(busy), .opDone(opDone),
   .totalStates(totalStates), .statesLeft(statesLeft));

// [tb/ist_loc_model.sv]
// Access location model: on-chip memory or a fast or slow peripheral.
// Assumes place is held steady for the whole instruction.
`timescale 1ns/10ps
module ist_loc_model (
   input  wire logic [1:0] place,
   output logic            codePeri,
   output logic            dataPeri,
   output logic            slowPeri
);
   // Place 3 also runs code from a peripheral, to exercise its price
   assign codePeri = place == 2'h3;
   assign dataPeri = place != 2'h0;
   assign slowPeri = place == 2'h2;
endmodule : ist_loc_model

// [tb/ist_state_timer_tb.sv]
// Testbench for the instruction state timer with a location model.
// Assumes the design answers within a few dozen cycles per instruction.
`timescale 1ns/10ps
module ist_state_timer_tb;
   logic sys_clk = 1'b0, nrst = 1'b0, opStart = 1'b0;
   logic codePeri, dataPeri, slowPeri, busy, opDone;
   logic [1:0] place = 2'h0;
   logic [7:0] totalStates;
   logic [7:0] statesLeft;
   ist_pkg::ist_op_e opClass = ist_pkg::IST_OP_ADD_REG;
   int fails = 0, testsRun = 0, cyc = 0;
   ist_loc_model lm (.place(place), .codePeri(codePeri),
      .dataPeri(dataPeri), .slowPeri(slowPeri));
   ist_state_timer uut (.sys_clk(sys_clk), .nrst(nrst), .opStart(opStart),
      .opClass(opClass), .fetchPeri(codePeri), .brAddrPeri(codePeri),
      .stackPeri(codePeri), .dataPeri(dataPeri), .slowPeri(slowPeri),
      .busy(busy), .opDone(opDone), .totalStates(totalStates),
      .statesLeft(statesLeft));
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic check(input logic ok, input string m);
      testsRun++;
      if (ok !== 1'b1) begin
         fails++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : check
   // A start mid-run (poke) must be dropped without changing anything
   task automatic run_op(input ist_pkg::ist_op_e c, input logic [1:0] p,
                         input logic [7:0] t, input bit poke);
      int k;
      opClass = c;
      place = p;
      opStart = 1'b1;
      @(negedge sys_clk);
      opStart = 1'b0;
      opClass = ist_pkg::IST_OP_ADD_REG;
      @(negedge sys_clk);
      check(totalStates === t && busy === 1'b1, "total at load");
      k = 1;
      while (opDone !== 1'b1 && k < 40) begin
         check(statesLeft === t - (k - 1), "states left");
         opStart = poke && k == 2;
         @(negedge sys_clk);
         k++;
      end
      check(k == t + 1 && totalStates === t, "done timing");
      check(busy === 1'b0 && statesLeft === 8'h00, "idle at done");
   endtask : run_op
   task automatic t_add_small_constant_word;
      run_op(ist_pkg::IST_OP_ADD_REG, 2'h0, 8'h02, 0);
      run_op(ist_pkg::IST_OP_ADD_SMALL, 2'h0, 8'h02, 0);
      run_op(ist_pkg::IST_OP_ADD_EXTEND, 2'h1, 8'h02, 0);
      $display("test add_small_constant_word done");
   endtask : t_add_small_constant_word
   task automatic t_flow;
      run_op(ist_pkg::IST_OP_SHORT_BR, 2'h0, 8'h04, 0);
      run_op(ist_pkg::IST_OP_CALL_IND, 2'h0, 8'h08, 1);
      run_op(ist_pkg::IST_OP_CALL_IND, 2'h3, 8'h08, 0);
      $display("test flow done");
   endtask : t_flow
   task automatic t_bits;
      run_op(ist_pkg::IST_OP_BIT_LOGIC_M, 2'h0, 8'h06, 0);
      run_op(ist_pkg::IST_OP_BIT_LOGIC_M, 2'h2, 8'h07, 0);
      run_op(ist_pkg::IST_OP_BIT_SETCL_M, 2'h1, 8'h08, 0);
      run_op(ist_pkg::IST_OP_BIT_SETCL_M, 2'h2, 8'h0A, 1);
      run_op(ist_pkg::IST_OP_BIT_REG, 2'h0, 8'h02, 0);
      $display("test bits done");
   endtask : t_bits
   // Reset in mid-instruction must clear every output, then work resumes
   task automatic t_reset;
      opClass = ist_pkg::IST_OP_CALL_IND;
      place = 2'h0;
      opStart = 1'b1;
      @(negedge sys_clk);
      opStart = 1'b0;
      repeat (3) @(negedge sys_clk);
      nrst = 1'b0;
      @(negedge sys_clk);
      check(busy === 1'b0 && opDone === 1'b0, "flags in reset");
      check(totalStates === 8'h00, "total in reset");
      check(statesLeft === 8'h00, "left in reset");
      nrst = 1'b1;
      run_op(ist_pkg::IST_OP_ADD_REG, 2'h0, 8'h02, 0);
      $display("test reset done");
   endtask : t_reset
   initial begin
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      t_add_small_constant_word();
      t_flow();
      t_bits();
      t_reset();
      end_of_test();
   end
endmodule : ist_state_timer_tb
